// file: alm_pkg.sv
// Package for the audio level and DC measurement control bank.
// Assumes byte-wide registers reached through a decoded control port.
package alm_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_AUX_HI        = 8'h02;
  localparam logic [7:0] ADDR_AUX_LO        = 8'h03;
  localparam logic [7:0] ADDR_PLAY_VOL_L    = 8'h1C;
  localparam logic [7:0] ADDR_PLAY_VOL_R    = 8'h1D;
  localparam logic [7:0] ADDR_LINEOUT_L     = 8'h1E;
  localparam logic [7:0] ADDR_LINEOUT_R     = 8'h1F;
  localparam logic [7:0] ADDR_MIC_GAIN_L    = 8'h20;
  localparam logic [7:0] ADDR_MIC_GAIN_R    = 8'h21;
  localparam logic [7:0] ADDR_ADC_IN_SEL    = 8'h22;
  localparam logic [7:0] ADDR_CONV_ENABLE   = 8'h26;
  // Writable bit masks; all other bits read as zero.
  localparam logic [7:0] MASK_PLAY_VOL      = 8'h7F;
  localparam logic [7:0] MASK_LINEOUT       = 8'h4F;
  localparam logic [7:0] MASK_MIC_GAIN      = 8'h7F;
  localparam logic [7:0] MASK_ADC_IN_SEL    = 8'hFF;
  localparam logic [7:0] MASK_CONV_ENABLE   = 8'hC0;
  // Field positions.
  localparam int POS_PLAY_MUTE              = 6;
  localparam int POS_LINEOUT_MUTE           = 6;
  localparam int POS_MIC_PREAMP             = 5;
  localparam int POS_MEASURE_HOLD           = 3;
  localparam int POS_MEASURE_GAIN_CAL       = 2;
  localparam int POS_MEASURE_OFFSET_CAL     = 1;
  localparam int POS_MEASURE_INPUT_ENABLE   = 0;
  localparam int POS_LEFT_CONV_ENABLE       = 7;
  localparam int POS_RIGHT_CONV_ENABLE      = 6;
  // Reset values.
  localparam logic [7:0]  RST_REG           = 8'h00;
  localparam logic [15:0] RST_AUX           = 16'h0000;
  localparam logic [4:0]  RST_PGA           = 5'h00;
  // Volume and PGA code breakpoints.
  localparam logic [5:0] VOL_HALF_END       = 6'h06;
  localparam logic [5:0] VOL_ONE_END        = 6'h0F;
  localparam logic [5:0] VOL_TWO_END        = 6'h17;
  localparam logic [5:0] VOL_FOUR_END       = 6'h26;
  localparam logic [5:0] VOL_MUTE_START     = 6'h28;
  localparam logic [4:0] PGA_ZERO_START     = 5'h14;
endpackage : alm_pkg

// file: alm_ctrl.sv
// Control register bank for playback level, line output, microphone gain and DC measurement.
// Assumes the serial control port is decoded elsewhere into byte reads and writes on core_clk,
// and that zero-crossing detectors and the converter run outside and are sampled here.
`timescale 1ns/100ps
`default_nettype none
module alm_ctrl (
  // Clock and reset.
  input  wire logic                core_clk,
  input  wire logic                rstn,
  // Decoded control port.
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_wdata,
  output logic [7:0]               reg_rdata,
  // Mode configuration and zero-crossing pins.
  input  wire logic                zero_cross_gate_off,
  input  wire logic                play_zc_left,
  input  wire logic                play_zc_right,
  input  wire logic                mic_zc_left,
  input  wire logic                mic_zc_right,
  // Playback path controls.
  output logic                     play_mute_left,
  output logic                     play_mute_right,
  output logic signed [8:0]        play_gain_left_hdb,
  output logic signed [8:0]        play_gain_right_hdb,
  // Line output controls.
  output logic                     lineout_mute_left,
  output logic                     lineout_mute_right,
  output logic [4:0]               lineout_atten_left_db,
  output logic [4:0]               lineout_atten_right_db,
  // Microphone controls.
  output logic                     mic_power_left,
  output logic                     mic_power_right,
  output logic [4:0]               mic_preamp_left_db,
  output logic [4:0]               mic_preamp_right_db,
  output logic [4:0]               mic_pga_left_db,
  output logic [4:0]               mic_pga_right_db,
  // Converter and measurement path.
  output logic                     left_converter_enable,
  output logic                     right_converter_enable,
  output logic                     right_conv_dc_mode,
  output logic                     aux_pin_connect,
  output logic                     aux_ref_select,
  output logic                     offset_cancel_run,
  output logic [15:0]              offset_trim,
  input  wire logic [15:0]         aux_sample,
  input  wire logic                aux_sample_valid
);
  import alm_pkg::*;

  typedef struct packed {
    logic [7:0]  vol_l;
    logic [7:0]  vol_r;
    logic [7:0]  lo_l;
    logic [7:0]  lo_r;
    logic [7:0]  mic_l;
    logic [7:0]  mic_r;
    logic [7:0]  adc_in;
    logic [7:0]  conv_en;
    logic        mute_l;
    logic        mute_r;
    logic [4:0]  pga_l;
    logic [4:0]  pga_r;
    logic [15:0] aux;
    logic [15:0] offs;
    logic [3:0]  zc_s1;
    logic [3:0]  zc_s2;
    logic [3:0]  zc_d;
    logic [7:0]  rdata;
  } alm_state_t;

  alm_state_t st_ff;
  alm_state_t nxt_st;
  logic [3:0] zc_pulse;

  // Volume code to half-dB gain; codes above VOL_FOUR_END, mute codes included, return a fixed -162 and mute is flagged apart.
  function automatic logic signed [8:0] vol_hdb(input logic [5:0] c);
    logic signed [10:0] cw;
    logic signed [10:0] g;
    cw = signed'({5'h00, c});
    if (c <= VOL_HALF_END)      g = 11'sd18 - cw;
    else if (c <= VOL_ONE_END)  g = 11'sd24 - 11'sd2 * cw;
    else if (c <= VOL_TWO_END)  g = 11'sd54 - 11'sd4 * cw;
    else if (c <= VOL_FOUR_END) g = 11'sd146 - 11'sd8 * cw;
    else                        g = -11'sd162;
    return g[8:0];
  endfunction : vol_hdb

  function automatic logic [4:0] preamp_db(input logic [1:0] f);
    case (f)
      2'h1:    return 5'h00;
      2'h2:    return 5'h14;
      2'h3:    return 5'h1E;
      default: return 5'h00;
    endcase
  endfunction : preamp_db

  function automatic logic [4:0] pga_db(input logic [4:0] c);
    if (c >= PGA_ZERO_START) return 5'h00;
    return 5'h14 - c;
  endfunction : pga_db

  function automatic logic [7:0] apply_wr(input logic [7:0] old, input logic [7:0] d,
                                          input logic [7:0] m);
    return (d & m) | (old & ~m);
  endfunction : apply_wr

  // Rising edge of each synchronised zero-crossing pin: play L, play R, mic L, mic R.
  assign zc_pulse = st_ff.zc_s2 & ~st_ff.zc_d;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.zc_s1 = {mic_zc_right, mic_zc_left, play_zc_right, play_zc_left};
    nxt_st.zc_s2 = st_ff.zc_s1;
    nxt_st.zc_d  = st_ff.zc_s2;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_PLAY_VOL_L:  nxt_st.vol_l   = apply_wr(st_ff.vol_l, reg_wdata, MASK_PLAY_VOL);
        ADDR_PLAY_VOL_R:  nxt_st.vol_r   = apply_wr(st_ff.vol_r, reg_wdata, MASK_PLAY_VOL);
        ADDR_LINEOUT_L:   nxt_st.lo_l    = apply_wr(st_ff.lo_l, reg_wdata, MASK_LINEOUT);
        ADDR_LINEOUT_R:   nxt_st.lo_r    = apply_wr(st_ff.lo_r, reg_wdata, MASK_LINEOUT);
        ADDR_MIC_GAIN_L:  nxt_st.mic_l   = apply_wr(st_ff.mic_l, reg_wdata, MASK_MIC_GAIN);
        ADDR_MIC_GAIN_R:  nxt_st.mic_r   = apply_wr(st_ff.mic_r, reg_wdata, MASK_MIC_GAIN);
        ADDR_ADC_IN_SEL:  nxt_st.adc_in  = apply_wr(st_ff.adc_in, reg_wdata, MASK_ADC_IN_SEL);
        ADDR_CONV_ENABLE: nxt_st.conv_en = apply_wr(st_ff.conv_en, reg_wdata, MASK_CONV_ENABLE);
        default: ;
      endcase
    end
    // Unmute is immediate; mute waits for a play crossing unless gating is off; slew settings never enter this path.
    if (!st_ff.vol_l[POS_PLAY_MUTE])                 nxt_st.mute_l = 1'b0;
    else if (zero_cross_gate_off || zc_pulse[0])     nxt_st.mute_l = 1'b1;
    if (!st_ff.vol_r[POS_PLAY_MUTE])                 nxt_st.mute_r = 1'b0;
    else if (zero_cross_gate_off || zc_pulse[1])     nxt_st.mute_r = 1'b1;
    // PGA steps wait for a mic crossing; preamp steps from the mic gain registers apply at once.
    if (zc_pulse[2]) nxt_st.pga_l = st_ff.mic_l[4:0];
    if (zc_pulse[3]) nxt_st.pga_r = st_ff.mic_r[4:0];
    // The result tracks the converter unless held; calibrations feed the same path.
    if (aux_sample_valid && !st_ff.adc_in[POS_MEASURE_HOLD]) nxt_st.aux = aux_sample;
    // Trim is cleared only on rstn, so shutdown does not lose it.
    if (aux_sample_valid && st_ff.adc_in[POS_MEASURE_OFFSET_CAL]) nxt_st.offs = aux_sample;
    nxt_st.rdata = RST_REG;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_AUX_HI:      nxt_st.rdata = st_ff.aux[15:8];
        ADDR_AUX_LO:      nxt_st.rdata = st_ff.aux[7:0];
        ADDR_PLAY_VOL_L:  nxt_st.rdata = st_ff.vol_l;
        ADDR_PLAY_VOL_R:  nxt_st.rdata = st_ff.vol_r;
        ADDR_LINEOUT_L:   nxt_st.rdata = st_ff.lo_l;
        ADDR_LINEOUT_R:   nxt_st.rdata = st_ff.lo_r;
        ADDR_MIC_GAIN_L:  nxt_st.rdata = st_ff.mic_l;
        ADDR_MIC_GAIN_R:  nxt_st.rdata = st_ff.mic_r;
        ADDR_ADC_IN_SEL:  nxt_st.rdata = st_ff.adc_in;
        ADDR_CONV_ENABLE: nxt_st.rdata = st_ff.conv_en;
        default:          nxt_st.rdata = RST_REG;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_ff <= '{vol_l: RST_REG, vol_r: RST_REG, lo_l: RST_REG, lo_r: RST_REG, mic_l: RST_REG,
                 mic_r: RST_REG, adc_in: RST_REG, conv_en: RST_REG, mute_l: 1'b0, mute_r: 1'b0,
                 pga_l: RST_PGA, pga_r: RST_PGA, aux: RST_AUX, offs: RST_AUX, zc_s1: 4'h0,
                 zc_s2: 4'h0, zc_d: 4'h0, rdata: RST_REG};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata              = st_ff.rdata;
  // Volume codes in the mute range silence the path as well.
  assign play_mute_left         = st_ff.mute_l | (st_ff.vol_l[5:0] >= VOL_MUTE_START);
  assign play_mute_right        = st_ff.mute_r | (st_ff.vol_r[5:0] >= VOL_MUTE_START);
  assign play_gain_left_hdb     = vol_hdb(st_ff.vol_l[5:0]);
  assign play_gain_right_hdb    = vol_hdb(st_ff.vol_r[5:0]);
  assign lineout_mute_left      = st_ff.lo_l[POS_LINEOUT_MUTE];
  assign lineout_mute_right     = st_ff.lo_r[POS_LINEOUT_MUTE];
  assign lineout_atten_left_db  = {st_ff.lo_l[3:0], 1'b0};
  assign lineout_atten_right_db = {st_ff.lo_r[3:0], 1'b0};
  assign mic_power_left         = |st_ff.mic_l[POS_MIC_PREAMP +: 2];
  assign mic_power_right        = |st_ff.mic_r[POS_MIC_PREAMP +: 2];
  assign mic_preamp_left_db     = preamp_db(st_ff.mic_l[POS_MIC_PREAMP +: 2]);
  assign mic_preamp_right_db    = preamp_db(st_ff.mic_r[POS_MIC_PREAMP +: 2]);
  assign mic_pga_left_db        = pga_db(st_ff.pga_l);
  assign mic_pga_right_db       = pga_db(st_ff.pga_r);
  assign left_converter_enable  = st_ff.conv_en[POS_LEFT_CONV_ENABLE];
  assign right_converter_enable = st_ff.conv_en[POS_RIGHT_CONV_ENABLE];
  assign right_conv_dc_mode     = st_ff.adc_in[POS_MEASURE_INPUT_ENABLE];
  assign aux_pin_connect        = st_ff.adc_in[POS_MEASURE_INPUT_ENABLE]
                                  & ~st_ff.adc_in[POS_MEASURE_OFFSET_CAL]
                                  & ~st_ff.adc_in[POS_MEASURE_GAIN_CAL];
  assign aux_ref_select         = st_ff.adc_in[POS_MEASURE_GAIN_CAL];
  assign offset_cancel_run      = st_ff.adc_in[POS_MEASURE_OFFSET_CAL];
  assign offset_trim            = st_ff.offs;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_mute_gate_off: assert property (st_ff.vol_l[POS_PLAY_MUTE] && zero_cross_gate_off
                                      |=> st_ff.mute_l)
    else $error("Left mute not applied at once with gating off.");
  chk_mute_wait_zc: assert property (!st_ff.mute_r && !zero_cross_gate_off && !zc_pulse[1]
                                     |=> !st_ff.mute_r)
    else $error("Right mute applied without a zero crossing.");
  chk_unmute_clear: assert property (!st_ff.vol_l[POS_PLAY_MUTE] |=> !st_ff.mute_l)
    else $error("Left mute held after the mute bit cleared.");
  chk_vol_mute_code: assert property (st_ff.vol_r[5:0] >= 6'h28 |-> play_mute_right)
    else $error("Mute volume code did not mute.");
  chk_vol_step: assert property (st_ff.vol_l[5:0] == 6'h26 |-> play_gain_left_hdb == -9'sd158)
    else $error("Volume code 0x26 not decoded to -79 dB.");
  chk_pga_zc_only: assert property (!zc_pulse[2] |=> st_ff.pga_l == $past(st_ff.pga_l))
    else $error("Left mic gain changed without a zero crossing.");
  chk_pga_floor: assert property (st_ff.pga_r >= 5'h14 |-> mic_pga_right_db == 5'h00)
    else $error("Mic gain above 0x13 not 0 dB.");
  chk_hold_freeze: assert property (st_ff.adc_in[POS_MEASURE_HOLD] ##1 st_ff.adc_in[POS_MEASURE_HOLD]
                                    |-> $stable(st_ff.aux))
    else $error("Measurement result moved while held.");
  chk_track_update: assert property (aux_sample_valid && !st_ff.adc_in[POS_MEASURE_HOLD]
                                     |=> st_ff.aux == $past(aux_sample))
    else $error("Measurement result missed a sample.");
  chk_cal_isolate: assert property (st_ff.adc_in[POS_MEASURE_OFFSET_CAL] |-> !aux_pin_connect)
    else $error("Aux pin connected during offset calibration.");
  chk_lineout_gain: assert property (st_ff.lo_l[3:0] == 4'hF |-> lineout_atten_left_db == 5'd30)
    else $error("Line output code 0xF not -30 dB.");
  chk_gain_isolate: assert property (st_ff.adc_in[POS_MEASURE_GAIN_CAL]
                                     |-> !aux_pin_connect && aux_ref_select)
    else $error("Aux pin connected during gain calibration.");
  chk_trim_kept: assert property (!st_ff.adc_in[POS_MEASURE_OFFSET_CAL] |=> $stable(st_ff.offs))
    else $error("Offset trim moved outside offset calibration.");
  // The trim may only follow samples while offset calibration runs, so shutdown cannot disturb it.
endmodule : alm_ctrl
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the level and measurement control bank.
// Assumes the byte port contract: write visible next cycle, read data one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import alm_pkg::*;
  logic              core_clk, rstn, reg_wr, reg_rd, zero_cross_gate_off, m;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata;
  logic              play_zc_left, play_zc_right, mic_zc_left, mic_zc_right, aux_sample_valid;
  logic [15:0]       aux_sample, offset_trim, aux_m, trim_m;
  logic              play_mute_left, play_mute_right, lineout_mute_left, lineout_mute_right;
  logic signed [8:0] play_gain_left_hdb, play_gain_right_hdb;
  logic [4:0]        lineout_atten_left_db, lineout_atten_right_db, mic_preamp_left_db, mic_preamp_right_db;
  logic [4:0]        mic_pga_left_db, mic_pga_right_db;
  logic              mic_power_left, mic_power_right, left_converter_enable, right_converter_enable;
  logic              right_conv_dc_mode, aux_pin_connect, aux_ref_select, offset_cancel_run;
  int                errors, samples_checked, pl, seed;
  int                pre_tab [4] = '{0, 0, 20, 30};
  logic [7:0]        mdl [0:255];
  logic [7:0]        addrs [10] = '{8'h02, 8'h03, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h26};

  alm_ctrl uut (.*);

  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      8'h1C, 8'h1D, 8'h20, 8'h21: return 8'h7F;
      8'h1E, 8'h1F: return 8'h4F;
      8'h22: return 8'hFF;
      8'h26: return 8'hC0;
      default: return 8'h00;
    endcase
  endfunction : mask_of

  // Volume in half-dB steps; every code from the mute range reports the floor value.
  function automatic int vol_hdb(input int c);
    if (c <= 6) return 18 - c;
    if (c <= 15) return 12 - 2 * (c - 6);
    if (c <= 23) return -6 - 4 * (c - 15);
    if (c <= 38) return -38 - 8 * (c - 23);
    return -162;
  endfunction : vol_hdb

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    mdl[a] = d & mask_of(a);
  endtask : wr

  task automatic chk_rd(input logic [7:0] a);
    logic [7:0] e;
    e = (a == 8'h02) ? aux_m[15:8] : (a == 8'h03) ? aux_m[7:0] : mdl[a];
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    samples_checked++;
    if (reg_rdata !== e) begin
      errors++;
      $display("BAD %0t read %h got %h exp %h", $time, a, reg_rdata, e);
    end
  endtask : chk_rd

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_out

  // The hold bit decides whether the result follows; the trim follows only during offset calibration.
  task automatic feed(input logic [15:0] v);
    @(negedge core_clk);
    aux_sample = v;
    aux_sample_valid = 1'b1;
    @(negedge core_clk);
    aux_sample_valid = 1'b0;
    if (!mdl[8'h22][3]) aux_m = v;
    if (mdl[8'h22][1]) trim_m = v;
    tick(1);
  endtask : feed

  task automatic end_test(input string n);
    $display("test %s ended, checked %0d, errors %0d", n, samples_checked, errors);
  endtask : end_test

  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    {rstn, reg_wr, reg_rd, zero_cross_gate_off, aux_sample_valid} = '0;
    {play_zc_left, play_zc_right, mic_zc_left, mic_zc_right} = '0;
    {reg_addr, reg_wdata, aux_sample, aux_m, trim_m} = '0;
    errors = 0;
    samples_checked = 0;
    pl = 20;
    foreach (mdl[i]) mdl[i] = 8'h00;
    seed = $urandom(32'h3ab6);
    tick(6);
    rstn = 1'b1;
    foreach (addrs[i]) chk_rd(addrs[i]);
    chk_out(play_gain_left_hdb, 16'(vol_hdb(0)), "reset gain");
    end_test("reset");
    foreach (addrs[i]) begin
      wr(addrs[i], 8'($urandom));
      chk_rd(addrs[i]);
    end
    wr(8'h40, 8'hFF);
    chk_rd(8'h40);
    end_test("access");
    zero_cross_gate_off = 1'b1;
    for (int c = 0; c < 64; c++) begin
      wr(ADDR_PLAY_VOL_L, 8'(c));
      wr(ADDR_PLAY_VOL_R, 8'(63 - c));
      chk_out(play_gain_left_hdb, 16'(vol_hdb(c)), "vol left");
      chk_out(play_gain_right_hdb, 16'(vol_hdb(63 - c)), "vol right");
      chk_out(16'(play_mute_left), 16'(c >= 40), "code mute");
    end
    wr(ADDR_PLAY_VOL_L, 8'h40);
    tick(1);
    chk_out(16'(play_mute_left), 16'h1, "mute at once");
    wr(ADDR_PLAY_VOL_L, 8'h00);
    tick(1);
    chk_out(16'(play_mute_left), 16'h0, "unmute");
    zero_cross_gate_off = 1'b0;
    wr(ADDR_PLAY_VOL_R, 8'h40);
    tick(4);
    chk_out(16'(play_mute_right), 16'h0, "mute waits");
    play_zc_right = 1'b1;
    tick(4);
    play_zc_right = 1'b0;
    chk_out(16'(play_mute_right), 16'h1, "mute at crossing");
    end_test("playback");
    for (int c = 0; c < 16; c++) begin
      m = 1'($urandom);
      wr(ADDR_LINEOUT_L, {1'b0, m, 2'b00, 4'(c)});
      wr(ADDR_LINEOUT_R, {1'b1, ~m, 2'b11, 4'(15 - c)});
      chk_out(16'(lineout_atten_left_db), 16'(2 * c), "line left");
      chk_out(16'(lineout_atten_right_db), 16'(30 - 2 * c), "line right");
      chk_out({14'h0, lineout_mute_left, lineout_mute_right}, {14'h0, m, ~m}, "line mute");
      chk_rd(ADDR_LINEOUT_R);
    end
    end_test("line output");
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_MIC_GAIN_L, {1'b0, 2'(i), 5'(i)});
      wr(ADDR_MIC_GAIN_R, {1'b1, 2'(3 - i), 5'(31 - i)});
      chk_out(16'(mic_preamp_left_db), 16'(pre_tab[i % 4]), "preamp");
      chk_out(16'(mic_preamp_right_db), 16'(pre_tab[(3 - i) & 3]), "preamp right");
      chk_out({14'h0, mic_power_left, mic_power_right}, {14'h0, i % 4 != 0, (3 - i) % 4 != 0}, "power");
      chk_out(16'(mic_pga_left_db), 16'(pl), "pga waits");
      {mic_zc_left, mic_zc_right} = 2'b11;
      tick(4);
      {mic_zc_left, mic_zc_right} = 2'b00;
      pl = (i >= 20) ? 0 : 20 - i;
      chk_out(16'(mic_pga_left_db), 16'(pl), "pga left");
      chk_out(16'(mic_pga_right_db), 16'((31 - i >= 20) ? 0 : i - 11), "pga right");
    end
    end_test("microphone");
    wr(ADDR_CONV_ENABLE, 8'h80);
    chk_out({14'h0, left_converter_enable, right_converter_enable}, 16'h2, "left only");
    wr(ADDR_CONV_ENABLE, 8'hFF);
    chk_out({14'h0, left_converter_enable, right_converter_enable}, 16'h3, "converters");
    chk_rd(ADDR_CONV_ENABLE);
    wr(ADDR_ADC_IN_SEL, 8'h03);
    chk_out({13'h0, aux_pin_connect, offset_cancel_run, right_conv_dc_mode}, 16'h3, "offset cal");
    feed(16'($urandom));
    chk_out(offset_trim, trim_m, "trim");
    wr(ADDR_ADC_IN_SEL, 8'h05);
    chk_out({14'h0, aux_pin_connect, aux_ref_select}, 16'h1, "gain cal");
    feed(16'($urandom));
    wr(ADDR_ADC_IN_SEL, 8'h0D);
    feed(16'($urandom));
    chk_rd(ADDR_AUX_HI);
    chk_rd(ADDR_AUX_LO);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_ADC_IN_SEL, k[0] ? 8'h09 : 8'h01);
      chk_out(16'(aux_pin_connect), 16'h1, "pin routed");
      feed(16'($urandom));
      chk_rd(ADDR_AUX_HI);
      chk_rd(ADDR_AUX_LO);
      chk_out(offset_trim, trim_m, "trim kept");
    end
    end_test("measurement");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
